// file: design/power_seq_defines.svh
// constants for the power-on and boot-select block
// assumes a 100 MHz clock and inputs asynchronous to it
`ifndef POWER_SEQ_DEFINES_SVH
`define POWER_SEQ_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define SEQ_STEP_US 10
`define SEQ_STEP_CYCLES ((`SEQ_STEP_US * 1000) / `CLK_PERIOD_NS)
`define SEQ_STEPS 4
`define SYNC_STAGES 2
`define SYNC_RST_LEVELS 4'h4
`define STRAP_BOOT_MODULE 2'h0
`define STRAP_BOOT_CARRIER 2'h1
`endif

// file: design/power_seq_pkg.sv
// types for the power-on and boot-select block
// used by the sequencer; the synchroniser does not import it
package power_seq_pkg;
   typedef enum logic [2:0] {st_off, st_wait_good, st_ramp, st_on, st_ramp_down} seq_state_t;
   typedef enum logic [1:0] {boot_module, boot_carrier, boot_invalid} boot_src_t;
endpackage

// file: design/sync_bits.sv
// multi-bit two-flop synchroniser, reset to a given level
// assumes each bit is an independent level
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk, // clock
   input wire logic rst_n, // async reset, active low
   input wire logic [W-1:0] d, // asynchronous levels
   output logic [W-1:0] q // synchronised levels
);
   logic [W-1:0] meta_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// file: design/power_seq.sv
// power-on sequencer with button toggle and boot source select
// assumes carrier holds power good low until rails are stable
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defines.svh"
module power_seq
   import power_seq_pkg::*;
(
   input wire logic clk, // 100 MHz clock
   input wire logic rst_n, // async reset, active low
   input wire logic power_good_in, // carrier power good, high = ok
   input wire logic power_button_n, // debounced button, active low
   input wire logic boot_disable_low_n, // boot strap low bit
   input wire logic boot_disable_high_n, // boot strap high bit
   output logic sleep_main_supply_off_n, // low = main supply off
   output logic rails_enable, // onboard rails sequencing enable
   output logic power_on_done, // sequencing finished, running
   output logic boot_from_carrier, // select carrier flash
   output logic boot_strap_invalid // unsupported strap pattern
);
   localparam int CW = 20;
   localparam logic [CW-1:0] STEP_LAST = CW'(`SEQ_STEP_CYCLES - 1);
   localparam logic [2:0] STEPS_LAST = 3'(`SEQ_STEPS - 1);

   logic [3:0] sync_q;
   logic good_s, btn_n_s, dis_lo_s, dis_hi_s;
   seq_state_t state_ff, nxt_state;
   logic [CW-1:0] tick_ff, nxt_tick;
   logic [2:0] step_ff, nxt_step;
   logic btn_prev_ff, want_on_ff, nxt_want_on;
   logic sleep_n_ff, rails_ff, done_ff, carrier_ff, invalid_ff;

   sync_bits #(.W(4), .RST_VAL(`SYNC_RST_LEVELS)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({power_good_in, power_button_n, boot_disable_low_n, boot_disable_high_n}),
      .q(sync_q)
   );
   // reset levels: power bad, button idle, straps at module default
   assign good_s = sync_q[3];
   assign btn_n_s = sync_q[2];
   assign dis_lo_s = sync_q[1];
   assign dis_hi_s = sync_q[0];

   function automatic boot_src_t decode_boot(input logic hi, input logic lo);
      case ({hi, lo})
         `STRAP_BOOT_MODULE: decode_boot = boot_module;
         `STRAP_BOOT_CARRIER: decode_boot = boot_carrier;
         default: decode_boot = boot_invalid;
      endcase
   endfunction

   wire btn_press = btn_prev_ff & ~btn_n_s;
   wire tick_done = (tick_ff == STEP_LAST);
   wire step_done = tick_done && (step_ff == STEPS_LAST);
   wire boot_src_t boot_sel = decode_boot(dis_hi_s, dis_lo_s);

   // button toggles the operator request; drops with power good
   always_comb begin
      nxt_want_on = want_on_ff;
      if (!good_s) begin
         nxt_want_on = 1'h0;
      end else if (btn_press) begin
         nxt_want_on = ~want_on_ff;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_tick = tick_ff;
      nxt_step = step_ff;
      case (state_ff)
         st_off: begin
            nxt_tick = '0;
            nxt_step = '0;
            if (good_s) begin
               nxt_state = st_wait_good;
            end
         end
         st_wait_good: begin
            if (!good_s) begin
               nxt_state = st_off;
            end else if (want_on_ff) begin
               nxt_state = st_ramp;
            end
         end
         st_ramp: begin
            nxt_tick = tick_done ? '0 : tick_ff + CW'(1);
            if (tick_done) begin
               nxt_step = step_ff + 3'h1;
            end
            if (!good_s) begin
               nxt_state = st_off;
            end else if (!want_on_ff) begin
               nxt_state = st_ramp_down;
               nxt_tick = '0;
               nxt_step = '0;
            end else if (step_done) begin
               nxt_state = st_on;
            end
         end
         st_on: begin
            nxt_tick = '0;
            nxt_step = '0;
            if (!good_s) begin
               nxt_state = st_off;
            end else if (!want_on_ff) begin
               nxt_state = st_ramp_down;
            end
         end
         st_ramp_down: begin
            nxt_tick = tick_done ? '0 : tick_ff + CW'(1);
            if (!good_s) begin
               nxt_state = st_off;
            end else if (tick_done) begin
               nxt_state = st_wait_good;
            end
         end
         default: begin
            nxt_state = st_off;
         end
      endcase
   end

   wire nxt_main_on = (nxt_state == st_ramp) || (nxt_state == st_on);
   // rails follow the supply but drop at once with power good
   wire nxt_rails = nxt_main_on && good_s;
   wire nxt_done = (nxt_state == st_on);
   // straps only taken while off, so a running boot never sees them change
   wire strap_open = (state_ff == st_off) || (state_ff == st_wait_good);
   wire boot_is_carrier = (boot_sel == boot_carrier);
   wire boot_is_invalid = (boot_sel == boot_invalid);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= st_off;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_ff <= '0;
      end else begin
         tick_ff <= nxt_tick;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_ff <= '0;
      end else begin
         step_ff <= nxt_step;
      end
   end

   // idle level after reset, so no false press follows reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         btn_prev_ff <= 1'h1;
      end else begin
         btn_prev_ff <= btn_n_s;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         want_on_ff <= 1'h0;
      end else begin
         want_on_ff <= nxt_want_on;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_n_ff <= 1'h0;
      end else begin
         sleep_n_ff <= nxt_main_on;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rails_ff <= 1'h0;
      end else begin
         rails_ff <= nxt_rails;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_ff <= 1'h0;
      end else begin
         done_ff <= nxt_done;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_ff <= 1'h0;
      end else if (strap_open) begin
         carrier_ff <= boot_is_carrier;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         invalid_ff <= 1'h0;
      end else if (strap_open) begin
         invalid_ff <= boot_is_invalid;
      end
   end

   assign sleep_main_supply_off_n = sleep_n_ff;
   assign rails_enable = rails_ff;
   assign power_on_done = done_ff;
   assign boot_from_carrier = carrier_ff;
   assign boot_strap_invalid = invalid_ff;
endmodule
`default_nettype wire

// file: tb/power_seq_asserts.sv
// port checks for power_seq
// bound to every power_seq instance
`timescale 1ns/1ps
`default_nettype none
module power_seq_asserts (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic power_good_in, // power good
   input wire logic power_button_n, // button
   input wire logic boot_disable_low_n, // strap low
   input wire logic boot_disable_high_n, // strap high
   input wire logic sleep_main_supply_off_n, // sleep out
   input wire logic rails_enable, // rails
   input wire logic power_on_done, // done
   input wire logic boot_from_carrier, // carrier flash
   input wire logic boot_strap_invalid // bad strap
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_held_off; !power_good_in [*6]; endsequence
   sequence s_strap(logic [1:0] v); ({boot_disable_high_n, boot_disable_low_n} == v && !power_good_in) [*6]; endsequence
   property p_off; s_held_off |-> !sleep_main_supply_off_n && !rails_enable && !power_on_done; endproperty
   property p_carrier; s_strap(2'h1) |-> boot_from_carrier && !boot_strap_invalid; endproperty
   property p_module; s_strap(2'h0) |-> !boot_from_carrier && !boot_strap_invalid; endproperty
   property p_sync; $fell(power_button_n) |=> $stable(sleep_main_supply_off_n); endproperty
   property p_on; $rose(sleep_main_supply_off_n) |-> !$past(power_button_n, 2) && $past(power_good_in, 2); endproperty
   property p_done; power_on_done |-> sleep_main_supply_off_n && rails_enable; endproperty
   property p_ramp; $rose(sleep_main_supply_off_n) |-> !power_on_done [*8]; endproperty
   a_off: assert property (p_off) else $error("output on without power good");
   a_carrier: assert property (p_carrier) else $error("carrier strap ignored");
   a_module: assert property (p_module) else $error("module strap ignored");
   a_sync: assert property (p_sync) else $error("button acted unsynchronised");
   a_on: assert property (p_on) else $error("supply on without press");
   a_done: assert property (p_done) else $error("done with supply off");
   a_ramp: assert property (p_ramp) else $error("done without ramp");
endmodule
bind power_seq power_seq_asserts chk (.*);
`default_nettype wire

// file: tb/carrier_model.sv
// carrier board: power good delay, button, supply inverter
// runs on the bench clock
`timescale 1ns/1ps
`default_nettype none
module carrier_model #(parameter int DELAY = 100) (
   input wire logic clk, // clock
   input wire logic rails_up, // carrier rails stable
   input wire logic press, // operator press
   input wire logic sleep_n, // module sleep output
   output logic power_good, // to module
   output logic button_n, // debounced, active low
   output logic supply_on_n // main supply switch
);
   int cnt = 0;
   // power good delay kept short to bound the run time
   always @(posedge clk) begin
      cnt <= rails_up ? (cnt < DELAY ? cnt + 1 : cnt) : 0;
      power_good <= rails_up && cnt == DELAY;
      button_n <= !press;
   end
   assign supply_on_n = !sleep_n;
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for power_seq
// carrier model drives power good and button
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, rails_up = 1'b0, press = 1'b0, s_l = 1'b0, s_h = 1'b0;
   wire logic pg, btn_n, sup_n, sl_n, rails, done, carrier, invalid;
   int n_errors = 0, tests_run = 0;
   int c;
   always #5 clk = !clk;
   carrier_model #(.DELAY(100)) partner (.clk(clk), .rails_up(rails_up), .press(press), .sleep_n(sl_n),
      .power_good(pg), .button_n(btn_n), .supply_on_n(sup_n));
   power_seq dut (.clk(clk), .rst_n(rst_n), .power_good_in(pg), .power_button_n(btn_n),
      .boot_disable_low_n(s_l), .boot_disable_high_n(s_h), .sleep_main_supply_off_n(sl_n),
      .rails_enable(rails), .power_on_done(done), .boot_from_carrier(carrier), .boot_strap_invalid(invalid));
   task check(input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // outputs move on the rising edge, so they are read on the falling one
   task settle;
      @(negedge clk);
   endtask
   task push;
      press <= 1'b1;
      wc(8);
      press <= 1'b0;
      wc(1);
   endtask
   task results;
      if (n_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task t_refused;
      push();
      wc(20);
      settle();
      check({sl_n, rails, done, sup_n}, 4'h1);
   endtask
   task t_straps;
      for (int i = 0; i < 4; i++) begin
         wc(1);
         {s_h, s_l} <= 2'(i);
         wc(8);
         settle();
         check({2'h0, carrier, invalid}, (i == 1) ? 4'h2 : (i > 1) ? 4'h1 : 4'h0);
      end
      wc(1);
      {s_h, s_l} <= 2'h0;
   endtask
   task t_on_off;
      rails_up <= 1'b1;
      wc(110);
      push();
      c = 0;
      while (done !== 1'b1 && c < 5000) begin
         settle();
         c++;
      end
      check({sl_n, rails, done, sup_n}, 4'he);
      check({3'h0, c > 3985 && c < 4010}, 4'h1);
      wc(1);
      {s_h, s_l} <= 2'h1;
      wc(8);
      settle();
      check({2'h0, carrier, invalid}, 4'h0);
      wc(1);
      {s_h, s_l} <= 2'h0;
      push();
      wc(10);
      settle();
      check({sl_n, rails, done, sup_n}, 4'h1);
      wc(1100);
   endtask
   task t_pg_drop;
      push();
      wc(20);
      settle();
      check({sl_n, rails, done, sup_n}, 4'hc);
      wc(1);
      rails_up <= 1'b0;
      wc(8);
      settle();
      check({sl_n, rails, done, sup_n}, 4'h1);
      check({2'h0, carrier, invalid}, 4'h0);
   endtask
   initial begin
      wc(16);
      rst_n <= 1'b1;
      wc(4);
      t_refused();
      t_straps();
      t_on_off();
      t_pg_drop();
      results();
   end
   initial begin
      #300000;
      n_errors++;
      results();
   end
endmodule
`default_nettype wire
